// file: hw/slf_flags.sv
// Summary of operation
// - Two thresholds sort outages into three classes
// - Supply drop turns rails off, asserts reset
// - Supply drop drives both flags low
// - Recovery: rails after delay, then reset release
// - Flags held low until reset released
// - Long outage: long flag low, short high
// - Long case: clear pulse raises long flag
// - Medium outage: both flags high
// - Medium case: clear pulse changes nothing
// - Short outage: long flag high, short low
// - Short case: clear pulse raises short flag
// - Reset releases 85 ms after rail up
`timescale 1ns/1ps
`default_nettype none
`include "slf_regs.svh"

module slf_flags #(
  parameter logic [31:0] LONG_CYC  = 32'(`SLF_LONG_CYC),
  parameter logic [31:0] SHORT_CYC = 32'(`SLF_SHORT_CYC),
  parameter logic [31:0] POR_CYC   = 32'(`SLF_POR_CYC),
  parameter logic [31:0] RAIL_CYC  = 32'(`SLF_RAIL_CYC)
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic supply_ok,
  input  wire logic flag_clear_in,
  output var  logic rail_one,
  output var  logic rail_two,
  output var  logic rail_four,
  output var  logic system_reset_n,
  output var  logic long_outage_flag,
  output var  logic short_outage_flag
);
  import slf_pkg::*;

  // Accepted clear width in cycles; short enough to stay a define
  localparam logic [15:0] CLR_CYC = 16'(`SLF_CLEAR_CYC);

  slf_reg_t r_reg;    // Registered state
  slf_reg_t r_next;   // Next state
  logic     clr_fire; // One-cycle accept of a filtered clear

  // Maps the outage count onto a duration class
  function automatic slf_class_t classify(input logic [31:0] cnt);
    slf_class_t c;
    c = CLS_SHORT;
    if (cnt >= LONG_CYC) begin
      c = CLS_LONG;
    end else if (cnt >= SHORT_CYC) begin
      c = CLS_MEDIUM;
    end
    return c;
  endfunction : classify

  // Clear accepted once, at the cycle its width reaches the minimum
  assign clr_fire = r_reg.clr_s2 && !r_reg.clr_done &&
                    (r_reg.clr_cnt == CLR_CYC - 16'h1);

  // Next-state logic for the whole block
  always_comb begin
    r_next = r_reg;
    // Synchroniser: the first stage feeds only the second
    r_next.clr_s1 = flag_clear_in;
    r_next.clr_s2 = r_reg.clr_s1;
    // Width filter on the synchronised clear
    if (!r_reg.clr_s2) begin
      r_next.clr_cnt  = 16'h0;
      r_next.clr_done = 1'b0;
    end else if (clr_fire) begin
      r_next.clr_done = 1'b1;
    end else if (r_reg.clr_cnt != CLR_CYC - 16'h1) begin
      r_next.clr_cnt = r_reg.clr_cnt + 16'h1;
    end
    if (!supply_ok) begin
      // Any supply loss restarts the sequence, whatever the phase
      if (r_reg.state != ST_OUTAGE) begin
        // The first low cycle already counts, so a threshold is exact
        r_next.out_cnt = 32'h1;
      end else if (r_reg.out_cnt < LONG_CYC) begin
        // Saturate: past the long threshold the length no longer matters
        r_next.out_cnt = r_reg.out_cnt + 32'h1;
      end
      r_next.state   = ST_OUTAGE;
      r_next.rails   = 1'b0;
      r_next.rst_n   = 1'b0;
      r_next.long_f  = 1'b0;
      r_next.short_f = 1'b0;
    end else begin
      case (r_reg.state)
        ST_OUTAGE: begin
          // Supply back: fix the class now, before counters are reused
          r_next.cls     = classify(r_reg.out_cnt);
          r_next.dly_cnt = 32'h0;
          r_next.state   = ST_RAIL_WAIT;
        end
        ST_RAIL_WAIT: begin
          // Rails come up once the restart delay has run out
          if (r_reg.dly_cnt >= RAIL_CYC - 32'h1) begin
            r_next.rails   = 1'b1;
            r_next.dly_cnt = 32'h0;
            r_next.state   = ST_POR_WAIT;
          end else begin
            r_next.dly_cnt = r_reg.dly_cnt + 32'h1;
          end
        end
        ST_POR_WAIT: begin
          // Reset held low until the power-on delay has run out
          if (r_reg.dly_cnt >= POR_CYC - 32'h1) begin
            r_next.rst_n = 1'b1;
            r_next.state = ST_RUN;
            case (r_reg.cls)
              CLS_LONG: begin
                r_next.long_f  = 1'b0;
                r_next.short_f = 1'b1;
              end
              CLS_MEDIUM: begin
                r_next.long_f  = 1'b1;
                r_next.short_f = 1'b1;
              end
              default: begin
                r_next.long_f  = 1'b1;
                r_next.short_f = 1'b0;
              end
            endcase
          end else begin
            r_next.dly_cnt = r_reg.dly_cnt + 32'h1;
          end
        end
        ST_RUN: begin
          // A clear only raises flags; high flags stay high
          if (clr_fire) begin
            r_next.long_f  = 1'b1;
            r_next.short_f = 1'b1;
          end
        end
        default: begin
          // Unused codes fall back to a fresh outage
          r_next.state = ST_OUTAGE;
        end
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // First power-up is treated as a long outage
      r_reg          <= '0;
      r_reg.state    <= ST_OUTAGE;
      r_reg.cls      <= CLS_LONG;
      r_reg.out_cnt  <= LONG_CYC;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    rail_one          = r_reg.rails;
    rail_two          = r_reg.rails;
    rail_four         = r_reg.rails;
    system_reset_n    = r_reg.rst_n;
    long_outage_flag  = r_reg.long_f;
    short_outage_flag = r_reg.short_f;
  end

  // Checks on the sequence and the flags
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_drop_rails;
    clk_en && !supply_ok |=> !rail_one && !rail_two && !rail_four &&
                             !system_reset_n;
  endproperty
  a_drop_rails: assert property (p_drop_rails)
    else $error("rails or reset stayed up after supply drop");

  property p_drop_flags;
    clk_en && !supply_ok |=> !long_outage_flag && !short_outage_flag;
  endproperty
  a_drop_flags: assert property (p_drop_flags)
    else $error("flags not low after supply drop");

  property p_rails_first;
    $rose(system_reset_n) |-> rail_one && $past(rail_one) &&
                              r_reg.state == ST_RUN;
  endproperty
  a_rails_first: assert property (p_rails_first)
    else $error("reset released without rails up");

  property p_por_wait;
    $rose(rail_one) |-> !system_reset_n && r_reg.dly_cnt == 32'h0;
  endproperty
  a_por_wait: assert property (p_por_wait)
    else $error("power-on delay did not start at rail up");

  property p_flags_hidden;
    !system_reset_n |-> !long_outage_flag && !short_outage_flag;
  endproperty
  a_flags_hidden: assert property (p_flags_hidden)
    else $error("flag high while system reset held");

  property p_long_flags;
    $rose(system_reset_n) && r_reg.cls == CLS_LONG |->
      !long_outage_flag && short_outage_flag;
  endproperty
  a_long_flags: assert property (p_long_flags)
    else $error("wrong flags after long outage");

  property p_med_flags;
    $rose(system_reset_n) && r_reg.cls == CLS_MEDIUM |->
      long_outage_flag && short_outage_flag;
  endproperty
  a_med_flags: assert property (p_med_flags)
    else $error("wrong flags after medium outage");

  property p_short_flags;
    $rose(system_reset_n) && r_reg.cls == CLS_SHORT |->
      long_outage_flag && !short_outage_flag;
  endproperty
  a_short_flags: assert property (p_short_flags)
    else $error("wrong flags after short outage");

  property p_clear_raises;
    clr_fire && clk_en && supply_ok && r_reg.state == ST_RUN |=>
      long_outage_flag && short_outage_flag;
  endproperty
  a_clear_raises: assert property (p_clear_raises)
    else $error("accepted clear did not raise the flags");

  property p_med_hold;
    r_reg.state == ST_RUN && r_reg.cls == CLS_MEDIUM && supply_ok &&
      clk_en |=> long_outage_flag && short_outage_flag;
  endproperty
  a_med_hold: assert property (p_med_hold)
    else $error("medium outage flags changed");

  property p_filter;
    clr_fire |-> r_reg.clr_cnt == CLR_CYC - 16'h1 && $past(r_reg.clr_s2);
  endproperty
  a_filter: assert property (p_filter)
    else $error("clear accepted before minimum width");

  property p_classify;
    r_reg.state == ST_OUTAGE && supply_ok && clk_en |=>
      r_reg.cls == (($past(r_reg.out_cnt) >= LONG_CYC)  ? CLS_LONG   :
                    ($past(r_reg.out_cnt) >= SHORT_CYC) ? CLS_MEDIUM :
                                                          CLS_SHORT);
  endproperty
  a_classify: assert property (p_classify)
    else $error("outage class does not match its length");

  // Rails come up exactly when the restart delay has run out
  property p_rail_delay;
    $rose(rail_one) |-> $past(r_reg.state) == ST_RAIL_WAIT &&
                        $past(r_reg.dly_cnt) == RAIL_CYC - 32'h1;
  endproperty
  a_rail_delay: assert property (p_rail_delay)
    else $error("rails rose before the restart delay ran out");

  property p_por_len;
    $rose(system_reset_n) |-> $past(r_reg.dly_cnt) == POR_CYC - 32'h1;
  endproperty
  a_por_len: assert property (p_por_len)
    else $error("reset released before the power-on delay ran out");

  // Without an accepted clear or a supply drop the flags never move in the run phase
  property p_hold_run;
    r_reg.state == ST_RUN && supply_ok && clk_en && !clr_fire |=>
      $stable(long_outage_flag) && $stable(short_outage_flag);
  endproperty
  a_hold_run: assert property (p_hold_run)
    else $error("flags moved without an accepted clear");

  // Outage count starts at one and never passes the long threshold
  property p_out_first;
    r_reg.state != ST_OUTAGE && !supply_ok && clk_en |=>
      r_reg.out_cnt == 32'h1;
  endproperty
  a_out_first: assert property (p_out_first)
    else $error("outage count did not start at one");

  property p_out_sat;
    r_reg.state == ST_OUTAGE && !supply_ok && clk_en |=>
      r_reg.out_cnt <= LONG_CYC && r_reg.out_cnt != 32'h0;
  endproperty
  a_out_sat: assert property (p_out_sat)
    else $error("outage count left its range");

  // A low enable must hold every bit of state, counters included
  property p_freeze;
    !clk_en |=> $stable(r_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  c_long: cover property ($rose(system_reset_n) && r_reg.cls == CLS_LONG);
  c_med: cover property ($rose(system_reset_n) && r_reg.cls == CLS_MEDIUM);
  c_short: cover property ($rose(system_reset_n) && r_reg.cls == CLS_SHORT);
  c_clear: cover property (clr_fire && r_reg.state == ST_RUN);
  c_drop_run: cover property (!supply_ok && r_reg.state == ST_RUN);

endmodule : slf_flags
`default_nettype wire

// file: hw/slf_regs.svh
`ifndef SLF_REGS_SVH
`define SLF_REGS_SVH

// Clock period of the block clock
`define SLF_CLK_PERIOD_NS    64'd10

// Outage thresholds, milliseconds
`define SLF_LONG_THRESH_MS   64'd10000
`define SLF_SHORT_THRESH_MS  64'd1500

// Power-on reset delay and rail restart delay, microseconds
`define SLF_POR_DELAY_US     64'd85000
`define SLF_RAIL_RESTART_US  64'd1000

// Least width of a flag clear pulse, nanoseconds
`define SLF_CLEAR_MIN_NS     64'd10000

// Cycle counts derived from the times above
`define SLF_LONG_CYC   (`SLF_LONG_THRESH_MS * 64'd1000000 / `SLF_CLK_PERIOD_NS)
`define SLF_SHORT_CYC  (`SLF_SHORT_THRESH_MS * 64'd1000000 / `SLF_CLK_PERIOD_NS)
`define SLF_POR_CYC    (`SLF_POR_DELAY_US * 64'd1000 / `SLF_CLK_PERIOD_NS)
`define SLF_RAIL_CYC   (`SLF_RAIL_RESTART_US * 64'd1000 / `SLF_CLK_PERIOD_NS)
`define SLF_CLEAR_CYC  ((`SLF_CLEAR_MIN_NS + `SLF_CLK_PERIOD_NS - 64'd1) / `SLF_CLK_PERIOD_NS)

`endif

// file: hw/slf_pkg.sv
package slf_pkg;

  // Power sequence phases
  typedef enum logic [2:0] {
    ST_OUTAGE,
    ST_RAIL_WAIT,
    ST_POR_WAIT,
    ST_RUN
  } slf_state_t;

  // Outage duration classes
  typedef enum logic [1:0] {
    CLS_SHORT,
    CLS_MEDIUM,
    CLS_LONG
  } slf_class_t;

  // Whole state of the block
  typedef struct packed {
    slf_state_t  state;
    slf_class_t  cls;
    logic [31:0] out_cnt;
    logic [31:0] dly_cnt;
    logic        clr_s1;
    logic        clr_s2;
    logic [15:0] clr_cnt;
    logic        clr_done;
    logic        rails;
    logic        rst_n;
    logic        long_f;
    logic        short_f;
  } slf_reg_t;

endpackage : slf_pkg

// file: sim/slf_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side: pulses the flag clear and reads the outage flags
module slf_host_model (
  input  wire logic clk,
  input  wire logic system_reset_n,
  input  wire logic long_outage_flag,
  input  wire logic short_outage_flag,
  output var  logic flag_clear_in
);
  // Released clear line sits at its pull-down level
  initial flag_clear_in = 1'b0;

  // Clear pulse held for a chosen number of cycles
  task automatic send_clear(input int width);
    @(posedge clk);
    #1 flag_clear_in = 1'b1;
    repeat (width) @(posedge clk);
    #1 flag_clear_in = 1'b0;
  endtask : send_clear

  // Flags mean nothing while reset is low, so report validity
  task automatic read_flags(output logic [1:0] flags, output logic ok);
    ok = (system_reset_n === 1'b1);
    flags = {long_outage_flag, short_outage_flag};
  endtask : read_flags
endmodule : slf_host_model

`default_nettype wire

// file: sim/tb_slf_flags.sv
`timescale 1ns/1ps
`default_nettype none

module tb_slf_flags;
  import slf_pkg::*;
  // Short counts keep the run brief
  localparam logic [31:0] LONG = 400, SHORT = 100, POR = 20, RAIL = 5;
  logic clk = 1'b0, arst_n = 1'b0, supply_ok = 1'b1, clk_en = 1'b1;
  wire logic flag_clear_in;
  logic r1, r2, r4, rst_n, lf, sf;
  int num_errors = 0, num_checks = 0, cycles = 0;
  int corners[8] = '{98, 99, 100, 102, 398, 399, 400, 402};

  always #5 clk = ~clk;

  slf_flags #(.LONG_CYC(LONG), .SHORT_CYC(SHORT), .POR_CYC(POR),
    .RAIL_CYC(RAIL)) dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .supply_ok(supply_ok), .flag_clear_in(flag_clear_in), .rail_one(r1),
    .rail_two(r2), .rail_four(r4), .system_reset_n(rst_n),
    .long_outage_flag(lf), .short_outage_flag(sf));

  slf_host_model host (.clk(clk), .system_reset_n(rst_n),
    .long_outage_flag(lf), .short_outage_flag(sf),
    .flag_clear_in(flag_clear_in));

  // Expected {long, short} flags for an outage of dur cycles
  function automatic logic [1:0] exp_flags(input int dur);
    if (dur >= int'(LONG)) return 2'b01;
    if (dur < int'(SHORT)) return 2'b10;
    return 2'b11;
  endfunction : exp_flags

  task automatic check(input string name, input logic [1:0] seen,
                       input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Wait for reset release, then judge rails, delay and flags
  task automatic release_and_clear(input logic [1:0] e, input int w);
    int n;
    int nr;
    logic [1:0] f;
    logic ok;
    n = 0;
    nr = 0;
    // Sample a step after each edge, once the registers have settled
    while (rst_n !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
      if (nr == 0 && r1 === 1'b1) nr = n;
    end
    check("rails_reset_up", {r1 & r2 & r4, rst_n}, 2'b11);
    check("rail_delay", {1'b0, nr == int'(RAIL)}, 2'b01);
    check("por_delay", {1'b0, n - nr == int'(POR)}, 2'b01);
    host.read_flags(f, ok);
    check("flags_valid", {1'b0, ok}, 2'b01);
    check("flags_class", f, e);
    host.send_clear(w);
    repeat (3) @(posedge clk);
    #1;
    check("flags_cleared", {lf, sf}, (w < 1000) ? e : 2'b11);
  endtask : release_and_clear

  // Reset just released: first edge starts recovery, counted as long
  task automatic powerup(input int w);
    @(posedge clk);
    #1 check("rails_wait", {r1 | r2 | r4, rst_n}, 2'b00);
    release_and_clear(2'b01, w);
  endtask : powerup

  // Supply loss of dur counted cycles followed by recovery
  task automatic outage(input int dur);
    @(posedge clk);
    #1 supply_ok = 1'b0;
    // Enable low in the same step as the drop: the drop must not act while frozen
    clk_en = 1'b0;
    repeat (3) @(posedge clk);
    #1 check("frozen_rails_reset", {r1 & r2 & r4, rst_n}, 2'b11);
    check("frozen_flags", {lf, sf}, 2'b11);
    clk_en = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("drop_rails_reset", {r1 | r2 | r4, rst_n}, 2'b00);
    check("drop_flags", {lf, sf}, 2'b00);
    repeat (dur - 2) @(posedge clk);
    #1 supply_ok = 1'b1;
    @(posedge clk);
    #1 check("rails_wait", {r1 | r2 | r4, rst_n}, 2'b00);
    release_and_clear(exp_flags(dur), 1010 + $urandom_range(40));
  endtask : outage

  // Main sequence
  initial begin
    int d;
    void'($urandom(95365));
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    // Power-up counts as long; a clear one cycle short is ignored
    powerup(999);
    host.send_clear(1000);
    repeat (3) @(posedge clk);
    #1 check("powerup_clear", {lf, sf}, 2'b11);
    foreach (corners[i]) outage(corners[i]);
    // Reset in mid-run: outputs drop at once, then a long recovery
    @(posedge clk);
    #1 arst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 check("reset_rails_reset", {r1 | r2 | r4, rst_n}, 2'b00);
    check("reset_flags", {lf, sf}, 2'b00);
    arst_n = 1'b1;
    powerup(1000 + $urandom_range(50));
    for (int i = 0; i < 6; i++) begin
      case ($urandom_range(2))
        0: d = 3 + $urandom_range(SHORT - 6);
        1: d = SHORT + 2 + $urandom_range(LONG - SHORT - 4);
        default: d = LONG + 2 + $urandom_range(100);
      endcase
      outage(d);
    end
    print_verdict();
  end
endmodule : tb_slf_flags

`default_nettype wire
